// >>> core/dct_consts.svh
// Register offsets, field positions, reset values and timing counts for the dual counter/timer
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH
`define DCT_OFF_FIRST_LOW 12'h000
`define DCT_OFF_FIRST_HIGH 12'h004
`define DCT_OFF_SECOND_LOW 12'h008
`define DCT_OFF_SECOND_HIGH 12'h00C
`define DCT_OFF_CONTROL 12'h010
`define DCT_OFF_MODE 12'h014
`define DCT_OFF_CLKCTL 12'h018
`define DCT_OFF_IRQEN 12'h01C
`define DCT_OFF_INCFG 12'h020
`define DCT_OFF_STATUS 12'h024
// Control register bits
`define DCT_CTL_SECOND_FLAG 7
`define DCT_CTL_SECOND_RUN 6
`define DCT_CTL_FIRST_FLAG 5
`define DCT_CTL_FIRST_RUN 4
// Mode register: first timer in bits 3..0, second in 7..4
`define DCT_MODE_GATE 3
`define DCT_MODE_CT 2
`define DCT_MODE_SEL_HI 1
`define DCT_MODE_SEL_LO 0
`define DCT_MODE_SECOND_BASE 4
// Clock control register
`define DCT_CLK_FIRST_SYS 3
`define DCT_CLK_SECOND_SYS 4
`define DCT_CLK_SCALE_HI 1
`define DCT_CLK_SCALE_LO 0
// Interrupt enable register
`define DCT_IE_FIRST 1
`define DCT_IE_SECOND 3
// Input configuration register
`define DCT_IN_FIRST_GATE_SELECT_POL 3
`define DCT_IN_GATE1_POL 7
// Prescale divisors
`define DCT_DIV_SCALE0 12
`define DCT_DIV_SCALE1 4
`define DCT_DIV_SCALE2 48
`define DCT_DIV_SCALE3 8
`define DCT_DIV_WIDTH 6
`define DCT_RESET_BYTE 8'h00
`endif

// >>> core/dct_pkg.sv
// Types shared by the dual counter/timer files
`default_nettype none
package dct_pkg;
  typedef enum logic [1:0] {
    DCT_MODE_13BIT,
    DCT_MODE_16BIT,
    DCT_MODE_RELOAD8,
    DCT_MODE_SPLIT8
  } dct_mode_t;
  typedef enum logic [1:0] {
    DCT_SCALE_DIV12,
    DCT_SCALE_DIV4,
    DCT_SCALE_DIV48,
    DCT_SCALE_EXT8
  } dct_scale_t;
endpackage : dct_pkg
`default_nettype wire

// >>> core/dct_channel.sv
// One counter/timer channel: input conditioning, run gating and the count register
`default_nettype none
`include "dct_consts.svh"
module dct_channel
  import dct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  input wire dct_pkg::dct_mode_t mode,
  input wire logic count_sel,
  input wire logic gate_sel,
  input wire logic sys_sel,
  input wire logic run_bit,
  input wire logic gate_pol,
  input wire logic scale_tick,
  // Pins
  input wire logic count_pin,
  input wire logic gate_pin,
  // Software load
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [7:0] load_data,
  // State
  output logic [7:0] low_byte,
  output logic [7:0] high_byte,
  output logic overflow
);
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic gate_s1_ff, gate_s2_ff;
  logic [7:0] low_ff, high_ff;
  logic [15:0] nxt_count;
  logic tick;
  logic running;
  logic wrap;

  // Two-stage synchronisers; a third stage for the edge compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      gate_s1_ff <= 1'b0;
      gate_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= count_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      gate_s1_ff <= gate_pin;
      gate_s2_ff <= gate_s1_ff;
    end
  end

  // Edge found on synchronised samples: adds latency but one event per fall
  assign running = run_bit && (!gate_sel || (gate_s2_ff == gate_pol));
  always_comb begin
    if (count_sel) begin
      tick = pin_s3_ff && !pin_s2_ff;
    end else if (sys_sel) begin
      tick = 1'b1;
    end else begin
      tick = scale_tick;
    end
  end

  always_comb begin
    nxt_count = {high_ff, low_ff};
    wrap = 1'b0;
    if (mode == DCT_MODE_16BIT) begin
      nxt_count = {high_ff, low_ff} + 16'h0001;
      wrap = ({high_ff, low_ff} == 16'hFFFF);
    end else begin
      // Every mode but 16-bit counts as 13-bit: low byte carries out of bit 4; upper bits left as stored
      nxt_count = {high_ff, low_ff[7:5], 5'h00} | {8'h00, 3'h0, low_ff[4:0] + 5'h01};
      if (low_ff[4:0] == 5'h1F) begin
        nxt_count[15:8] = high_ff + 8'h01;
      end
      wrap = (high_ff == 8'hFF) && (low_ff[4:0] == 5'h1F);
    end
  end

  // Software loads take priority; run does not alter the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_ff <= `DCT_RESET_BYTE;
      high_ff <= `DCT_RESET_BYTE;
    end else if (load_low || load_high) begin
      if (load_low) begin
        low_ff <= load_data;
      end
      if (load_high) begin
        high_ff <= load_data;
      end
    end else if (running && tick) begin
      low_ff <= nxt_count[7:0];
      high_ff <= nxt_count[15:8];
    end
  end

  assign overflow = running && tick && wrap && !(load_low || load_high);
  assign low_byte = low_ff;
  assign high_byte = high_ff;
endmodule : dct_channel
`default_nettype wire

// >>> core/dct_top.sv
// Dual counter/timer with AHB-Lite register slave
// Notes on behaviour
// - Each timer reads its mode field independently; every code but 16-bit counts as 13-bit.
// - Timer clock is one of six sources: sysclk, four prescales (12, 4, 48, 8), or count pin.
// - Counter mode adds one per falling edge of the timer's count pin.
// - Events up to a quarter of system clock rate are counted correctly.
// - Count is sixteen bits, read and written as separate low and high bytes.
// - 13-bit mode: high byte eight upper bits, low byte bits 4..0 lower five.
// - Rollover from all ones to zero sets overflow flag, control bit 5.
// - Mode bit 2 set counts pin falls; clear uses internal clock.
// - Clock control bit 3 set uses system clock, else prescaled clock.
// - Counts when run bit set and gate off or gate input active.
// - Setting run bit neither clears nor reloads the count.
// - Second timer mirrors first with its own bits and second gate polarity.
// - Overflow requests interrupt only when its enable bit is set.
// - 16-bit mode behaves like 13-bit mode but uses all sixteen bits.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`default_nettype none
`include "dct_consts.svh"
module dct_top
  import dct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer pins
  input wire logic count_pin_zero,
  input wire logic count_pin_one,
  input wire logic external_gate_zero,
  input wire logic external_gate_one,
  // Interrupt requests
  output logic first_overflow_irq,
  output logic second_overflow_irq
);
  import dct_pkg::*;

  logic [7:0] timer_control_register_ff;
  logic [7:0] timer_mode_register_ff;
  logic [7:0] clock_control_register_ff;
  logic [7:0] interrupt_enable_register_ff;
  logic [7:0] external_input_config_ff;
  logic wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [`DCT_DIV_WIDTH-1:0] div_ff;
  logic [`DCT_DIV_WIDTH-1:0] div_lim;
  logic scale_tick;
  logic [7:0] first_timer_low_byte, first_timer_high_byte;
  logic [7:0] second_timer_low_byte, second_timer_high_byte;
  logic first_ovf, second_ovf;
  logic addr_phase;
  logic wr_ctl;
  logic [7:0] wbyte;
  logic [7:0] nxt_control;
  logic [31:0] nxt_rdata;

  assign addr_phase = hsel && hready && htrans[1];
  assign wbyte = hwdata[7:0];
  assign wr_ctl = wr_pend_ff && (wr_addr_ff == `DCT_OFF_CONTROL);

  // Write data lands in the data phase, so the address is held one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_ff <= {haddr[11:2], 2'b00};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_mode_register_ff <= `DCT_RESET_BYTE;
      clock_control_register_ff <= `DCT_RESET_BYTE;
      interrupt_enable_register_ff <= `DCT_RESET_BYTE;
      external_input_config_ff <= `DCT_RESET_BYTE;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `DCT_OFF_MODE: timer_mode_register_ff <= wbyte;
        `DCT_OFF_CLKCTL: clock_control_register_ff <= wbyte;
        `DCT_OFF_IRQEN: interrupt_enable_register_ff <= wbyte;
        `DCT_OFF_INCFG: external_input_config_ff <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // Overflow set wins over a software clear in the same cycle
  always_comb begin
    nxt_control = timer_control_register_ff;
    if (wr_ctl) begin
      nxt_control = wbyte;
    end
    if (first_ovf) begin
      nxt_control[`DCT_CTL_FIRST_FLAG] = 1'b1;
    end
    if (second_ovf) begin
      nxt_control[`DCT_CTL_SECOND_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_register_ff <= `DCT_RESET_BYTE;
    end else begin
      timer_control_register_ff <= nxt_control;
    end
  end

  // Shared prescaler; external-oscillator choice falls back to divide by 8 of hclk
  always_comb begin
    case (dct_scale_t'(clock_control_register_ff[`DCT_CLK_SCALE_HI:`DCT_CLK_SCALE_LO]))
      DCT_SCALE_DIV12: div_lim = `DCT_DIV_WIDTH'(`DCT_DIV_SCALE0 - 1);
      DCT_SCALE_DIV4: div_lim = `DCT_DIV_WIDTH'(`DCT_DIV_SCALE1 - 1);
      DCT_SCALE_DIV48: div_lim = `DCT_DIV_WIDTH'(`DCT_DIV_SCALE2 - 1);
      default: div_lim = `DCT_DIV_WIDTH'(`DCT_DIV_SCALE3 - 1);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= '0;
    end else if (div_ff >= div_lim) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + `DCT_DIV_WIDTH'(1);
    end
  end
  assign scale_tick = (div_ff >= div_lim);

  dct_channel u_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(dct_mode_t'(timer_mode_register_ff[`DCT_MODE_SEL_HI:`DCT_MODE_SEL_LO])),
    .count_sel(timer_mode_register_ff[`DCT_MODE_CT]),
    .gate_sel(timer_mode_register_ff[`DCT_MODE_GATE]),
    .sys_sel(clock_control_register_ff[`DCT_CLK_FIRST_SYS]),
    .run_bit(timer_control_register_ff[`DCT_CTL_FIRST_RUN]),
    .gate_pol(external_input_config_ff[`DCT_IN_FIRST_GATE_SELECT_POL]),
    .scale_tick(scale_tick),
    .count_pin(count_pin_zero),
    .gate_pin(external_gate_zero),
    .load_low(wr_pend_ff && (wr_addr_ff == `DCT_OFF_FIRST_LOW)),
    .load_high(wr_pend_ff && (wr_addr_ff == `DCT_OFF_FIRST_HIGH)),
    .load_data(wbyte),
    .low_byte(first_timer_low_byte),
    .high_byte(first_timer_high_byte),
    .overflow(first_ovf)
  );

  dct_channel u_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(dct_mode_t'(timer_mode_register_ff[`DCT_MODE_SECOND_BASE+1:`DCT_MODE_SECOND_BASE])),
    .count_sel(timer_mode_register_ff[`DCT_MODE_SECOND_BASE+`DCT_MODE_CT]),
    .gate_sel(timer_mode_register_ff[`DCT_MODE_SECOND_BASE+`DCT_MODE_GATE]),
    .sys_sel(clock_control_register_ff[`DCT_CLK_SECOND_SYS]),
    .run_bit(timer_control_register_ff[`DCT_CTL_SECOND_RUN]),
    .gate_pol(external_input_config_ff[`DCT_IN_GATE1_POL]),
    .scale_tick(scale_tick),
    .count_pin(count_pin_one),
    .gate_pin(external_gate_one),
    .load_low(wr_pend_ff && (wr_addr_ff == `DCT_OFF_SECOND_LOW)),
    .load_high(wr_pend_ff && (wr_addr_ff == `DCT_OFF_SECOND_HIGH)),
    .load_data(wbyte),
    .low_byte(second_timer_low_byte),
    .high_byte(second_timer_high_byte),
    .overflow(second_ovf)
  );

  // Read mux; unmapped offsets read zero
  always_comb begin
    case ({haddr[11:2], 2'b00})
      `DCT_OFF_FIRST_LOW: nxt_rdata = {24'h000000, first_timer_low_byte};
      `DCT_OFF_FIRST_HIGH: nxt_rdata = {24'h000000, first_timer_high_byte};
      `DCT_OFF_SECOND_LOW: nxt_rdata = {24'h000000, second_timer_low_byte};
      `DCT_OFF_SECOND_HIGH: nxt_rdata = {24'h000000, second_timer_high_byte};
      `DCT_OFF_CONTROL: nxt_rdata = {24'h000000, timer_control_register_ff};
      `DCT_OFF_MODE: nxt_rdata = {24'h000000, timer_mode_register_ff};
      `DCT_OFF_CLKCTL: nxt_rdata = {24'h000000, clock_control_register_ff};
      `DCT_OFF_IRQEN: nxt_rdata = {24'h000000, interrupt_enable_register_ff};
      `DCT_OFF_INCFG: nxt_rdata = {24'h000000, external_input_config_ff};
      `DCT_OFF_STATUS: nxt_rdata = {30'h0, second_overflow_irq, first_overflow_irq};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Interrupt requests follow the flags, gated by enables
  assign first_overflow_irq = timer_control_register_ff[`DCT_CTL_FIRST_FLAG] &&
                              interrupt_enable_register_ff[`DCT_IE_FIRST];
  assign second_overflow_irq = timer_control_register_ff[`DCT_CTL_SECOND_FLAG] &&
                               interrupt_enable_register_ff[`DCT_IE_SECOND];
endmodule : dct_top
`default_nettype wire

// >>> verification/dct_asserts.sv
// Port checks for the dual counter/timer top
`default_nettype none
module dct_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Requests
  input wire logic first_overflow_irq,
  input wire logic second_overflow_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic req = hsel && hready && htrans[1];
  wire logic rd = req && !hwrite;
  wire logic wr = req && hwrite;
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  // Read data is registered, so it may only move after a read address phase
  a_rdata_held: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
  a_status_irq: assert property (rd && haddr[11:2] == 10'h009 |=>
    hrdata[1:0] == {$past(second_overflow_irq), $past(first_overflow_irq)})
    else $error("status differs from requests");
  a_unmapped_zero: assert property (rd && haddr[11:2] > 10'h009 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_fall_write: assert property (
    $fell(first_overflow_irq) || $fell(second_overflow_irq) |-> $past(wr, 2))
    else $error("request dropped without write");
  a_reset_quiet: assert property (
    $rose(hresetn) |-> !first_overflow_irq && !second_overflow_irq)
    else $error("request after reset");
endmodule // dct_asserts
bind dct_top dct_asserts i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .first_overflow_irq, .second_overflow_irq);
`default_nettype wire

// >>> verification/dct_pins_model.sv
// Outside circuitry on the count pins and gate inputs
`default_nettype none
module dct_pins_model (
  // Clock
  input wire logic hclk,
  // Pins
  output logic count_pin_zero,
  output logic count_pin_one,
  output logic external_gate_zero,
  output logic external_gate_one
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {count_pin_one, count_pin_zero} = 2'h3;
    {external_gate_one, external_gate_zero} = 2'h0;
  end
  // Each level held two clocks: the fastest event rate allowed
  task automatic pulse(input logic [1:0] pins, input int n);
    repeat (n) begin
      {count_pin_one, count_pin_zero} <= ~pins;
      repeat (2) @(posedge hclk);
      {count_pin_one, count_pin_zero} <= 2'h3;
      repeat (2) @(posedge hclk);
    end
  endtask
  // Spare clocks let the synchronised gate settle
  task automatic set_gate(input logic g0, input logic g1);
    external_gate_zero <= g0;
    external_gate_one <= g1;
    repeat (4) @(posedge hclk);
  endtask
endmodule // dct_pins_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the dual counter/timer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  logic count_pin_zero, count_pin_one, external_gate_zero, external_gate_one;
  logic first_overflow_irq, second_overflow_irq;
  int mismatches = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  dct_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .count_pin_zero, .count_pin_one,
    .external_gate_zero, .external_gate_one, .first_overflow_irq, .second_overflow_irq);
  dct_pins_model i_pins (.hclk, .count_pin_zero, .count_pin_one, .external_gate_zero,
    .external_gate_one);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic close_out;
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 64; i++) begin
      @(posedge hclk);
      if (hready === 1'b1)
        return;
    end
    mismatches++;
    close_out;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_ready;
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    check(q & m, e);
  endtask
  task automatic s_reset;
    for (int i = 0; i < 12; i++)
      rc(12'(i * 4), 32'hFFFFFFFF, 32'h00000000);
    wr(12'h024, 8'hFF);
    rc(12'h024, 32'hFF, 32'h00);
  endtask
  task automatic s_wrap;
    wr(12'h014, 8'h54);
    wr(12'h01C, 8'h02);
    wr(12'h004, 8'hFF);
    wr(12'h000, 8'hFE);
    wr(12'h00C, 8'hFF);
    wr(12'h008, 8'hFE);
    wr(12'h010, 8'h50);
    i_pins.pulse(2'h3, 1);
    rc(12'h000, 32'h1F, 32'h1F);
    rc(12'h004, 32'hFF, 32'hFF);
    rc(12'h008, 32'hFF, 32'hFF);
    check({31'h0, first_overflow_irq}, 32'h0);
    i_pins.pulse(2'h3, 1);
    rc(12'h000, 32'h1F, 32'h00);
    rc(12'h004, 32'hFF, 32'h00);
    rc(12'h008, 32'hFF, 32'h00);
    rc(12'h00C, 32'hFF, 32'h00);
    rc(12'h010, 32'hFF, 32'hF0);
    rc(12'h024, 32'hFF, 32'h01);
    check({30'h0, second_overflow_irq, first_overflow_irq}, 32'h1);
    wr(12'h01C, 8'h0A);
    rc(12'h024, 32'hFF, 32'h03);
    wr(12'h010, 8'h00);
    @(posedge hclk);
    check({30'h0, second_overflow_irq, first_overflow_irq}, 32'h0);
  endtask
  task automatic s_gate;
    wr(12'h014, 8'hDD);
    wr(12'h020, 8'h08);
    wr(12'h000, 8'h10);
    wr(12'h008, 8'h20);
    i_pins.set_gate(1'b0, 1'b1);
    wr(12'h010, 8'h50);
    i_pins.pulse(2'h3, 2);
    rc(12'h000, 32'hFF, 32'h10);
    rc(12'h008, 32'hFF, 32'h20);
    i_pins.set_gate(1'b1, 1'b0);
    // One fall on the first pin alone catches swapped pin wiring
    i_pins.pulse(2'h1, 1);
    i_pins.pulse(2'h3, 2);
    rc(12'h000, 32'hFF, 32'h13);
    rc(12'h008, 32'hFF, 32'h22);
    wr(12'h010, 8'h00);
    i_pins.pulse(2'h3, 1);
    rc(12'h000, 32'hFF, 32'h13);
    rc(12'h008, 32'hFF, 32'h22);
  endtask
  task automatic s_scale;
    int dv [5] = '{1, 12, 4, 48, 8};
    logic [7:0] ck [5] = '{8'h18, 8'h00, 8'h01, 8'h02, 8'h03};
    logic ok;
    wr(12'h014, 8'h11);
    for (int i = 0; i < 5; i++) begin
      wr(12'h018, ck[i]);
      wr(12'h000, 8'h00);
      wr(12'h008, 8'h00);
      wr(12'h010, 8'h50);
      // Prescaler phase is unknown, so allow a small spread
      repeat (192) @(posedge hclk);
      wr(12'h010, 8'h00);
      rc(12'h004, 32'hFF, 32'h00);
      rc(12'h00C, 32'hFF, 32'h00);
      xfer(1'b0, 12'h000, 8'h00);
      ok = q >= 192 / dv[i] && q <= 192 / dv[i] + 3;
      check({31'h0, ok}, 32'h1);
      xfer(1'b0, 12'h008, 8'h00);
      ok = q >= 192 / dv[i] && q <= 192 / dv[i] + 3;
      check({31'h0, ok}, 32'h1);
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset;
    s_wrap;
    s_gate;
    s_scale;
    close_out;
  end
endmodule // tb_top
`default_nettype wire
